// ===== src/rail_seq_cfg.svh
// constants for the rail sequencer: slot tables, timing, flag positions
`ifndef RAIL_SEQ_CFG_SVH
`define RAIL_SEQ_CFG_SVH

`define RAIL_COUNT 8
`define SLOT_W 3
`define TABLE_W 24
`define FIRST_SLOT 3'h0
`define LAST_SLOT 3'h4
`define SLOT_STEP 3'h1

// slot per rail, rail one in the low three bits
// default slots for power-up, power-down, sleep exit and sleep entry
`define PWR_UP_TABLE {3'h2, 3'h1, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1}
`define PWR_DOWN_TABLE {3'h3, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h1, 3'h4}
`define SLP_EXIT_TABLE {3'h3, 3'h1, 3'h2, 3'h0, 3'h0, 3'h3, 3'h1, 3'h0}
`define SLP_ENTRY_TABLE {3'h2, 3'h3, 3'h1, 3'h0, 3'h0, 3'h2, 3'h3, 3'h0}

// slot interval
`define SLOT_TIME_NS 625000
`define CLK_PERIOD_NS 10

// synchroniser bit positions and idle levels
`define SYNC_W 4
`define PIN_ACT 0
`define PIN_SLEEP 1
`define PIN_EMPD 2
`define PIN_SYSRST 3
`define SYNC_RESET 4'hE

// fault flag layout
`define FLAGS_RESET 8'h00
`define RAILS_RESET 8'h00
`define FF1_SYSRST_BIT 0
`define FF1_CHECK_BIT 1
`define FF1_EMPD_BIT 2
`define FF2_PWRUP_ABORT_BIT 0
`define FF2_SLEEP_ABORT_BIT 1

`endif

// ===== src/rail_seq_pkg.sv
// types shared by the rail sequencer modules
package rail_seq_pkg;
	typedef enum logic [2:0] {
		st_off = 3'b000,
		st_pwr_up = 3'b001,
		st_active = 3'b010,
		st_slp_entry = 3'b011,
		st_sleep = 3'b100,
		st_slp_exit = 3'b101,
		st_pwr_down = 3'b110
	} seq_state_t;
	typedef logic [2:0] slot_t;
	typedef logic [7:0] rail_vec_t;
endpackage : rail_seq_pkg

// ===== src/slot_timer_if.sv
// carrier between the sequencer and its slot interval timer
`timescale 1ns/1ps
interface slot_timer_if;
	logic run;
	logic restart;
	logic tick;
	modport ctrl (output run, output restart, input tick);
	modport timer (input run, input restart, output tick);
endinterface : slot_timer_if

// ===== src/pin_sync.sv
// two-flop synchroniser for the asynchronous control pins
`timescale 1ns/1ps
`include "rail_seq_cfg.svh"
module pin_sync #(
	parameter int WIDTH = `SYNC_W,
	parameter logic [`SYNC_W-1:0] RESET_VAL = `SYNC_RESET
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);
	// one pair of flops per pin
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_sync
			logic meta_q;
			logic stable_q;
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					meta_q <= RESET_VAL[i];
					stable_q <= RESET_VAL[i];
				end else begin
					meta_q <= pin_in[i];
					stable_q <= meta_q;
				end
			end
			assign pin_sync_out[i] = stable_q;
		end
	endgenerate
endmodule : pin_sync

// ===== src/slot_timer.sv
// slot interval counter, one tick per elapsed slot interval
`timescale 1ns/1ps
`include "rail_seq_cfg.svh"
module slot_timer #(
	parameter int SLOT_CYCLES = `SLOT_TIME_NS / `CLK_PERIOD_NS
) (
	input wire logic ref_clk,
	input wire logic rst,
	slot_timer_if.timer tmr
);
	localparam int CNT_W = $clog2(SLOT_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SLOT_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] gap_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= CNT_ZERO;
		end else if (!tmr.run || tmr.restart || cnt_q == CNT_LAST) begin
			cnt_q <= CNT_ZERO;
		end else begin
			cnt_q <= cnt_q + CNT_ONE;
		end
	end

	assign tmr.tick = tmr.run && !tmr.restart && cnt_q == CNT_LAST;

	// independent gap count, read only by the check below
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gap_q <= CNT_ZERO;
		end else if (!tmr.run || tmr.restart || tmr.tick) begin
			gap_q <= CNT_ZERO;
		end else begin
			gap_q <= gap_q + CNT_ONE;
		end
	end

	tick_gap_a: assert property (@(posedge ref_clk) disable iff (rst)
		tmr.tick |-> gap_q == CNT_LAST)
		else $error("slot tick not one interval after the last");
endmodule : slot_timer

// ===== src/rail_sequencer_control.sv
// rail sequencer: power, sleep and emergency sequencing with fault flags
// Summary of operation
// - activation high starts power-up and leads to the active state.
// - activation low takes the device through power-down to shutdown.
// - the open-drain fault interrupt is driven low while any flag is set.
// - system reset line pulled low by others sets a fault flag.
// - the kind of fault is shown by separate flag bits.
// - every sequencing failure is latched in the flag registers.
// - a flag clears only on a one written to it; zero leaves it.
// - a flag stays set after its cause goes until cleared.
// - sleep input low runs the sleep-entry sequence into sleep.
// - sleep input high runs the sleep-exit sequence back to active.
// - emergency power-down input low starts the power-down sequence.
// - default slot tables for all four sequences are built in.
// - power-up and power-down slots are 625 us apart.
// - sleep-exit and sleep-entry slots are 625 us apart.
// - power-up slots: 1,2,7 in 1; 3,4,8 in 2; 5 in 3; 6 in 4.
// - sleep-exit slots: 1,4,5 in 0; 2,7 in 1; 6 in 2; 3,8 in 3.
// - each rail has its own sleep-entry slot apart from its sleep-exit slot.
// - a wrong packet check byte raises the fault interrupt.
`timescale 1ns/1ps
`include "rail_seq_cfg.svh"
module rail_sequencer_control #(
	parameter int SLOT_CYCLES = `SLOT_TIME_NS / `CLK_PERIOD_NS,
	parameter logic [`TABLE_W-1:0] PWR_UP_SLOTS = `PWR_UP_TABLE,
	parameter logic [`TABLE_W-1:0] PWR_DOWN_SLOTS = `PWR_DOWN_TABLE,
	parameter logic [`TABLE_W-1:0] SLP_EXIT_SLOTS = `SLP_EXIT_TABLE,
	parameter logic [`TABLE_W-1:0] SLP_ENTRY_SLOTS = `SLP_ENTRY_TABLE
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic activation_input,
	input wire logic sleep_in_n,
	input wire logic emergency_powerdown_in_n,
	input wire logic system_reset_line_n,
	input wire logic packet_check_byte_error,
	input wire logic [7:0] fault_flags_first_clear,
	input wire logic [7:0] fault_flags_second_clear,
	output logic [7:0] fault_flags_first,
	output logic [7:0] fault_flags_second,
	output logic fault_interrupt_out,
	output logic fault_interrupt_out_oe_n,
	output logic powered_off_state,
	output logic sequence_busy,
	output logic rail_enable_one,
	output logic rail_enable_two,
	output logic rail_enable_three,
	output logic rail_enable_four,
	output logic rail_enable_five,
	output logic rail_enable_six,
	output logic rail_enable_seven,
	output logic rail_enable_eight
);
	rail_seq_pkg::seq_state_t state_q;
	rail_seq_pkg::seq_state_t state_d;
	rail_seq_pkg::slot_t slot_q;
	rail_seq_pkg::slot_t slot_d;
	rail_seq_pkg::rail_vec_t rails_q;
	rail_seq_pkg::rail_vec_t rails_d;
	rail_seq_pkg::rail_vec_t hit;
	rail_seq_pkg::rail_vec_t flags1_q;
	rail_seq_pkg::rail_vec_t flags1_d;
	rail_seq_pkg::rail_vec_t flags1_set;
	rail_seq_pkg::rail_vec_t flags2_q;
	rail_seq_pkg::rail_vec_t flags2_d;
	rail_seq_pkg::rail_vec_t flags2_set;
	logic [`TABLE_W-1:0] table_sel;
	logic [`SYNC_W-1:0] pins;
	logic act_s;
	logic sleep_s;
	logic empd_s;
	logic sysrst_s;
	logic go;
	logic step;
	logic irq_q;
	logic seq_state;
	logic powered;

	slot_timer_if tmr ();

	pin_sync #(
		.WIDTH(`SYNC_W),
		.RESET_VAL(`SYNC_RESET)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.pin_in({system_reset_line_n, emergency_powerdown_in_n, sleep_in_n,
			activation_input}),
		.pin_sync_out(pins)
	);

	slot_timer #(
		.SLOT_CYCLES(SLOT_CYCLES)
	) u_slot_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.tmr(tmr.timer)
	);

	// synchronised pin levels
	assign act_s = pins[`PIN_ACT];
	assign sleep_s = pins[`PIN_SLEEP];
	assign empd_s = pins[`PIN_EMPD];
	assign sysrst_s = pins[`PIN_SYSRST];

	// state classes
	assign seq_state = state_q == rail_seq_pkg::st_pwr_up ||
		state_q == rail_seq_pkg::st_pwr_down ||
		state_q == rail_seq_pkg::st_slp_entry ||
		state_q == rail_seq_pkg::st_slp_exit;
	assign powered = state_q != rail_seq_pkg::st_off &&
		state_q != rail_seq_pkg::st_pwr_down;

	// state transitions; go marks entry into a new sequence
	always_comb begin
		state_d = state_q;
		go = 1'b0;
		case (state_q)
			rail_seq_pkg::st_off: begin
				if (act_s && empd_s) begin
					state_d = rail_seq_pkg::st_pwr_up;
					go = 1'b1;
				end
			end
			rail_seq_pkg::st_pwr_up: begin
				if (!act_s || !empd_s) begin
					state_d = rail_seq_pkg::st_pwr_down;
					go = 1'b1;
				end else if (tmr.tick && slot_q == `LAST_SLOT) begin
					state_d = rail_seq_pkg::st_active;
				end
			end
			rail_seq_pkg::st_active: begin
				if (!act_s || !empd_s) begin
					state_d = rail_seq_pkg::st_pwr_down;
					go = 1'b1;
				end else if (!sleep_s) begin
					state_d = rail_seq_pkg::st_slp_entry;
					go = 1'b1;
				end
			end
			rail_seq_pkg::st_slp_entry: begin
				if (!act_s || !empd_s) begin
					state_d = rail_seq_pkg::st_pwr_down;
					go = 1'b1;
				end else if (tmr.tick && slot_q == `LAST_SLOT) begin
					state_d = rail_seq_pkg::st_sleep;
				end
			end
			rail_seq_pkg::st_sleep: begin
				if (!act_s || !empd_s) begin
					state_d = rail_seq_pkg::st_pwr_down;
					go = 1'b1;
				end else if (sleep_s) begin
					state_d = rail_seq_pkg::st_slp_exit;
					go = 1'b1;
				end
			end
			rail_seq_pkg::st_slp_exit: begin
				if (!act_s || !empd_s) begin
					state_d = rail_seq_pkg::st_pwr_down;
					go = 1'b1;
				end else if (tmr.tick && slot_q == `LAST_SLOT) begin
					state_d = rail_seq_pkg::st_active;
				end
			end
			rail_seq_pkg::st_pwr_down: begin
				if (tmr.tick && slot_q == `LAST_SLOT) begin
					state_d = rail_seq_pkg::st_off;
				end
			end
			default: begin
				state_d = rail_seq_pkg::st_off;
			end
		endcase
	end

	assign step = seq_state && tmr.tick && slot_q != `LAST_SLOT && !go;
	always_comb begin
		slot_d = slot_q;
		if (go) begin
			slot_d = `FIRST_SLOT;
		end else if (step) begin
			slot_d = slot_q + `SLOT_STEP;
		end
	end

	// built-in tables, chosen by the sequence being entered
	always_comb begin
		case (state_d)
			rail_seq_pkg::st_pwr_up: table_sel = PWR_UP_SLOTS;
			rail_seq_pkg::st_slp_exit: table_sel = SLP_EXIT_SLOTS;
			rail_seq_pkg::st_slp_entry: table_sel = SLP_ENTRY_SLOTS;
			default: table_sel = PWR_DOWN_SLOTS;
		endcase
	end

	// rails whose slot is reached now
	genvar r;
	generate
		for (r = 0; r < `RAIL_COUNT; r++) begin : g_hit
			assign hit[r] = (go || step) && table_sel[r*`SLOT_W +: `SLOT_W] == slot_d;
		end
	endgenerate

	// assert on power-up and sleep exit, release on power-down and sleep entry
	always_comb begin
		rails_d = rails_q;
		if (state_d == rail_seq_pkg::st_pwr_up || state_d == rail_seq_pkg::st_slp_exit) begin
			rails_d = rails_q | hit;
		end else if (state_d == rail_seq_pkg::st_pwr_down ||
			state_d == rail_seq_pkg::st_slp_entry) begin
			rails_d = rails_q & ~hit;
		end
	end

	// sequencer state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= rail_seq_pkg::st_off;
			slot_q <= `FIRST_SLOT;
		end else begin
			state_q <= state_d;
			slot_q <= slot_d;
		end
	end

	// rail enable flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rails_q <= `RAILS_RESET;
		end else begin
			rails_q <= rails_d;
		end
	end

	// timer runs through each sequence, restarted on entry
	assign tmr.run = seq_state;
	assign tmr.restart = go;

	// fault sources, one bit per kind
	always_comb begin
		flags1_set = `FLAGS_RESET;
		flags2_set = `FLAGS_RESET;
		flags1_set[`FF1_SYSRST_BIT] = !sysrst_s;
		flags1_set[`FF1_CHECK_BIT] = packet_check_byte_error;
		flags1_set[`FF1_EMPD_BIT] = !empd_s && powered;
		flags2_set[`FF2_PWRUP_ABORT_BIT] = state_q == rail_seq_pkg::st_pwr_up && go;
		flags2_set[`FF2_SLEEP_ABORT_BIT] = go && state_d == rail_seq_pkg::st_pwr_down &&
			(state_q == rail_seq_pkg::st_slp_entry || state_q == rail_seq_pkg::st_slp_exit);
	end

	// write-one clear, set wins over clear
	assign flags1_d = (flags1_q & ~fault_flags_first_clear) | flags1_set;
	assign flags2_d = (flags2_q & ~fault_flags_second_clear) | flags2_set;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			flags1_q <= `FLAGS_RESET;
			flags2_q <= `FLAGS_RESET;
		end else begin
			flags1_q <= flags1_d;
			flags2_q <= flags2_d;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |flags1_d || |flags2_d;
		end
	end

	// outputs
	assign fault_flags_first = flags1_q;
	assign fault_flags_second = flags2_q;
	assign fault_interrupt_out = 1'b0;
	assign fault_interrupt_out_oe_n = !irq_q;
	assign powered_off_state = state_q == rail_seq_pkg::st_off;
	assign sequence_busy = seq_state;
	assign rail_enable_one = rails_q[0];
	assign rail_enable_two = rails_q[1];
	assign rail_enable_three = rails_q[2];
	assign rail_enable_four = rails_q[3];
	assign rail_enable_five = rails_q[4];
	assign rail_enable_six = rails_q[5];
	assign rail_enable_seven = rails_q[6];
	assign rail_enable_eight = rails_q[7];

	// checks
	sequence s_slot_tick(rail_seq_pkg::seq_state_t st, rail_seq_pkg::slot_t sl);
		state_q == st && slot_q == sl && tmr.tick && act_s && empd_s;
	endsequence
	sequence s_awake;
		act_s && empd_s;
	endsequence

	pwr_up_start_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_awake and (state_q == rail_seq_pkg::st_off)) |=> state_q == rail_seq_pkg::st_pwr_up)
		else $error("activation did not start power-up");

	shutdown_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
		state_q == rail_seq_pkg::st_active && !act_s |=>
		state_q == rail_seq_pkg::st_pwr_down && slot_q == `FIRST_SLOT)
		else $error("activation low did not start power-down");

	irq_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
		(|flags1_q || |flags2_q) == !fault_interrupt_out_oe_n)
		else $error("interrupt pin disagrees with flags");

	reset_line_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
		!sysrst_s |=> flags1_q[`FF1_SYSRST_BIT] && !fault_interrupt_out_oe_n)
		else $error("reset line low not flagged");

	flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(flags1_q[`FF1_CHECK_BIT]) |-> $past(fault_flags_first_clear[`FF1_CHECK_BIT]))
		else $error("flag dropped without a clear");

	flag_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
		flags2_q[`FF2_PWRUP_ABORT_BIT] && !fault_flags_second_clear[`FF2_PWRUP_ABORT_BIT]
		|=> flags2_q[`FF2_PWRUP_ABORT_BIT])
		else $error("flag lost without a clear");

	sleep_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_awake and (state_q == rail_seq_pkg::st_active && !sleep_s)) |=>
		state_q == rail_seq_pkg::st_slp_entry)
		else $error("sleep low did not start sleep entry");

	sleep_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_awake and (state_q == rail_seq_pkg::st_sleep && sleep_s)) |=>
		state_q == rail_seq_pkg::st_slp_exit)
		else $error("sleep high did not start sleep exit");

	empd_down_a: assert property (@(posedge ref_clk) disable iff (rst)
		powered && !empd_s |=> state_q == rail_seq_pkg::st_pwr_down ##1
		flags1_q[`FF1_EMPD_BIT])
		else $error("emergency input did not power down");

	pwr_up_slot1_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_slot_tick(rail_seq_pkg::st_pwr_up, 3'h0) |=> rails_q == 8'h43)
		else $error("power-up slot 1 rails wrong");

	slp_exit_slot0_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_awake and (state_q == rail_seq_pkg::st_sleep && sleep_s)) ##1
		state_q == rail_seq_pkg::st_slp_exit |-> (rails_q & 8'h19) == 8'h19)
		else $error("sleep-exit slot 0 rails not on");

	slot_step_a: assert property (@(posedge ref_clk) disable iff (rst)
		step |=> slot_q == $past(slot_q) + `SLOT_STEP)
		else $error("slot did not advance by one");

	check_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
		packet_check_byte_error |=> flags1_q[`FF1_CHECK_BIT] && !fault_interrupt_out_oe_n)
		else $error("bad check byte did not raise interrupt");
endmodule : rail_sequencer_control

// ===== bench/safety_host_model.sv
// partner model: safety controller, soc sleep control and flag-clearing host
`timescale 1ns/1ps
module safety_host_model (
	input wire logic ref_clk,
	output logic activation_input,
	output logic sleep_in_n,
	output logic emergency_powerdown_in_n,
	output logic system_reset_line_n,
	output logic packet_check_byte_error,
	output logic [7:0] fault_flags_first_clear,
	output logic [7:0] fault_flags_second_clear
);
	// idle levels from time zero, pulled-up lines high
	initial begin
		activation_input = 1'h0;
		sleep_in_n = 1'h1;
		emergency_powerdown_in_n = 1'h1;
		system_reset_line_n = 1'h1;
		packet_check_byte_error = 1'h0;
		fault_flags_first_clear = 8'h00;
		fault_flags_second_clear = 8'h00;
	end

	task automatic set_pins(input logic act, input logic slp_n, input logic em_n,
		input logic line_n);
		@(posedge ref_clk);
		activation_input <= act;
		sleep_in_n <= slp_n;
		emergency_powerdown_in_n <= em_n;
		system_reset_line_n <= line_n;
	endtask : set_pins

	task automatic write_clear(input logic [7:0] first, input logic [7:0] second);
		@(posedge ref_clk);
		fault_flags_first_clear <= first;
		fault_flags_second_clear <= second;
		@(posedge ref_clk);
		fault_flags_first_clear <= 8'h00;
		fault_flags_second_clear <= 8'h00;
	endtask : write_clear

	// one-cycle bad check byte report
	task automatic pulse_check_error;
		@(posedge ref_clk);
		packet_check_byte_error <= 1'h1;
		@(posedge ref_clk);
		packet_check_byte_error <= 1'h0;
	endtask : pulse_check_error
endmodule : safety_host_model

// ===== bench/test_rail_sequencer_control.sv
// self-checking testbench for the rail sequencer
`timescale 1ns/1ps
module test_rail_sequencer_control;
	localparam int SLOT = 8;
	// slot per rail: power-up, power-down, sleep entry, sleep exit
	localparam int SLOTS [4][8] = '{'{1, 1, 2, 2, 3, 4, 1, 2}, '{4, 1, 3, 3, 2, 1, 1, 3},
		'{0, 3, 2, 0, 0, 1, 3, 2}, '{0, 1, 3, 0, 0, 2, 1, 3}};
	logic ref_clk;
	logic rst;
	logic act, slp_n, em_n, line_n, chk_err;
	logic [7:0] clr1, clr2, flags1, flags2;
	logic irq, oe_n, off, busy;
	rail_seq_pkg::rail_vec_t rails;
	int err_total;
	int num_checks;

	safety_host_model host (.ref_clk(ref_clk), .activation_input(act), .sleep_in_n(slp_n),
		.emergency_powerdown_in_n(em_n), .system_reset_line_n(line_n),
		.packet_check_byte_error(chk_err), .fault_flags_first_clear(clr1),
		.fault_flags_second_clear(clr2));

	rail_sequencer_control #(.SLOT_CYCLES(SLOT)) DUT (.ref_clk(ref_clk), .rst(rst),
		.activation_input(act), .sleep_in_n(slp_n), .emergency_powerdown_in_n(em_n),
		.system_reset_line_n(line_n), .packet_check_byte_error(chk_err),
		.fault_flags_first_clear(clr1), .fault_flags_second_clear(clr2),
		.fault_flags_first(flags1), .fault_flags_second(flags2), .fault_interrupt_out(irq),
		.fault_interrupt_out_oe_n(oe_n), .powered_off_state(off), .sequence_busy(busy),
		.rail_enable_one(rails[0]), .rail_enable_two(rails[1]), .rail_enable_three(rails[2]),
		.rail_enable_four(rails[3]), .rail_enable_five(rails[4]), .rail_enable_six(rails[5]),
		.rail_enable_seven(rails[6]), .rail_enable_eight(rails[7]));

	// free-running 100 MHz clock
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp, input string msg);
		chk8({7'h00, got}, {7'h00, exp}, msg);
	endtask : chk1

	task automatic chk_num(input int got, input int exp, input string msg);
		num_checks++;
		if (got != exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
		end
	endtask : chk_num

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// bounded wait on busy (0), interrupt enable (1) or off (2)
	task automatic wait_sig(input int which, input logic lvl);
		logic got;
		int n;
		n = 0;
		got = ~lvl;
		while (got !== lvl && n < 8 * SLOT) begin
			tick(1);
			n++;
			got = (which == 0) ? busy : (which == 1) ? oe_n : off;
		end
		if (got !== lvl) begin
			err_total++;
			$display("[FAIL] %0t wait on signal %0d ran out", $time, which);
			final_report();
		end
	endtask : wait_sig

	// follows one sequence slot by slot until it finishes
	task automatic check_seq(input int sel, input logic on);
		rail_seq_pkg::rail_vec_t prev, exp;
		int first, last, gap;
		first = 4;
		last = 0;
		for (int r = 0; r < 8; r++) begin
			if (SLOTS[sel][r] < first) first = SLOTS[sel][r];
			if (SLOTS[sel][r] > last) last = SLOTS[sel][r];
		end
		prev = rails;
		// only slots that own a rail show a change
		for (int s = first; s <= last; s++) begin
			gap = 0;
			while (rails === prev && gap < 6 * SLOT) begin
				tick(1);
				gap++;
			end
			if (rails === prev) begin
				err_total++;
				$display("[FAIL] %0t slot %0d never switched", $time, s);
				final_report();
			end
			for (int r = 0; r < 8; r++) begin
				exp[r] = (SLOTS[sel][r] <= s) ? on : ~on;
			end
			chk8(rails, exp, "slot rails");
			if (s > first) chk_num(gap, SLOT, "slot spacing");
			prev = rails;
		end
		wait_sig(0, 1'h0);
	endtask : check_seq

	task automatic test_reset_state;
		chk8(rails, 8'h00, "rails after reset");
		chk8(flags1, 8'h00, "first flags after reset");
		chk8(flags2, 8'h00, "second flags after reset");
		chk1(oe_n, 1'h1, "interrupt idle");
		chk1(irq, 1'h0, "open-drain data");
		chk1(off, 1'h1, "off after reset");
		chk1(busy, 1'h0, "idle after reset");
	endtask : test_reset_state

	task automatic test_power_cycle;
		host.set_pins(1'h1, 1'h1, 1'h1, 1'h1);
		check_seq(0, 1'h1);
		chk1(off, 1'h0, "powered after power-up");
		host.set_pins(1'h1, 1'h0, 1'h1, 1'h1);
		check_seq(2, 1'h0);
		host.set_pins(1'h1, 1'h1, 1'h1, 1'h1);
		check_seq(3, 1'h1);
		host.set_pins(1'h0, 1'h1, 1'h1, 1'h1);
		check_seq(1, 1'h0);
		chk1(off, 1'h1, "off after power-down");
		chk1(oe_n, 1'h1, "no interrupt on clean run");
	endtask : test_power_cycle

	task automatic test_emergency;
		host.set_pins(1'h1, 1'h1, 1'h1, 1'h1);
		check_seq(0, 1'h1);
		host.set_pins(1'h1, 1'h1, 1'h0, 1'h1);
		check_seq(1, 1'h0);
		chk8(flags1, 8'h04, "emergency flag");
		chk1(oe_n, 1'h0, "interrupt on emergency");
		host.set_pins(1'h0, 1'h1, 1'h1, 1'h1);
		tick(4);
		chk8(flags1, 8'h04, "flag held after cause");
		host.write_clear(8'hFB, 8'h00);
		#1;
		chk8(flags1, 8'h04, "zero write keeps flag");
		host.write_clear(8'h04, 8'h00);
		#1;
		chk8(flags1, 8'h00, "one write clears flag");
		chk1(oe_n, 1'h1, "interrupt released");
	endtask : test_emergency

	task automatic test_abort;
		host.set_pins(1'h1, 1'h1, 1'h1, 1'h1);
		tick(SLOT + 6);
		host.set_pins(1'h0, 1'h1, 1'h1, 1'h1);
		wait_sig(2, 1'h1);
		chk8(flags2, 8'h01, "power-up abort flag");
		chk8(rails, 8'h00, "rails off after abort");
		chk1(oe_n, 1'h0, "interrupt on abort");
		host.write_clear(8'h00, 8'h01);
		#1;
		chk8(flags2, 8'h00, "abort flag cleared");
	endtask : test_abort

	task automatic test_reset_line;
		host.set_pins(1'h0, 1'h1, 1'h1, 1'h0);
		wait_sig(1, 1'h0);
		chk8(flags1, 8'h01, "reset line flag");
		host.set_pins(1'h0, 1'h1, 1'h1, 1'h1);
		tick(4);
		chk8(flags1, 8'h01, "reset line flag held");
		host.write_clear(8'h01, 8'h00);
		#1;
		chk8(flags1, 8'h00, "reset line flag cleared");
		chk1(oe_n, 1'h1, "interrupt released");
	endtask : test_reset_line

	task automatic test_check_byte;
		host.pulse_check_error();
		#1;
		chk8(flags1, 8'h02, "bad check byte flag");
		chk1(oe_n, 1'h0, "interrupt on bad check byte");
		host.write_clear(8'h02, 8'h00);
		#1;
		chk8(flags1, 8'h00, "check byte flag cleared");
	endtask : test_check_byte

	// activation dropped while sleep entry runs
	task automatic test_sleep_abort;
		host.set_pins(1'h1, 1'h1, 1'h1, 1'h1);
		check_seq(0, 1'h1);
		host.set_pins(1'h1, 1'h0, 1'h1, 1'h1);
		tick(SLOT);
		host.set_pins(1'h0, 1'h0, 1'h1, 1'h1);
		wait_sig(2, 1'h1);
		chk8(flags2, 8'h02, "sleep abort flag");
		chk8(rails, 8'h00, "rails off after sleep abort");
		chk1(oe_n, 1'h0, "interrupt on sleep abort");
		host.write_clear(8'h00, 8'h02);
		#1;
		chk8(flags2, 8'h00, "sleep abort flag cleared");
	endtask : test_sleep_abort

	// reset, then the scenarios in turn
	initial begin
		err_total = 0;
		num_checks = 0;
		rst = 1'h1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'h0;
		tick(1);
		test_reset_state();
		test_power_cycle();
		test_emergency();
		test_abort();
		test_sleep_abort();
		test_reset_line();
		test_check_byte();
		final_report();
	end
endmodule : test_rail_sequencer_control
